// ==== hw/sps_host_end.sv ====
/*
 * host end: power-up and power-down sequencer with programmable intervals,
 * reference clock generator, serial byte master and interrupt input.
 * assumes the sensor end on the other side of sps_link_if; miso and
 * interrupt lines are pins; miso passes two flip-flops, the interrupt three.
 */
// Notes on behaviour
// - clock-domain supply on first, never later; the code raises it in the same cycle as enable and primary
// - enable and primary supplies order is free
// - on only after supplies stable, enable high
// - state-control held low during power-stable interval
// - crystal: wait oscillator settle before serial traffic
// - external clock: no oscillator settle needed
// - reference clock low while enable is low
// - after power-up load program, then start it
// - interrupt high impedance until program starts
// - host interrupt pin is input before start
// - interrupt is output, host interrupt request
// - optional state-control input selects idle state
// - shared four-wire slave bus, no daisy chain
// - power-down starts with enable low
// - crystal oscillator stops when enable low
// - reference clock stops together with enable
// - primary off, then clock supply after gap
// - all sensor inputs low by clock supply off
// - mode zero: sample rising, change falling
// - select low around transfer, released between
`timescale 1ns/1ps
`include "sps_params.svh"

module sps_host_end #(
    parameter int CW   = `SPS_CNT_W,
    parameter int HALF = `SPS_SPI_HALF_CYC
) (
    // clock and reset
    input  wire logic          clock,
    input  wire logic          nrst,
    // link
    sps_link_if.host           link,
    // sequence control
    input  wire logic          power_up_req,
    input  wire logic          power_down_req,
    input  wire logic          use_crystal,
    input  wire logic [CW-1:0] t1_cycles,
    input  wire logic [CW-1:0] t2_cycles,
    input  wire logic [CW-1:0] t3_cycles,
    input  wire logic          ctrl_req,
    // sequence status
    output logic               powered_up,
    output logic               powered_off,
    output logic               t1_done,
    output logic               t2_done,
    output logic               t3_done,
    output logic               irq_level,
    // serial bytes
    input  wire logic [7:0]    tx_byte,
    input  wire logic          tx_valid,
    output logic               tx_ready,
    output logic [7:0]         rx_byte,
    output logic               rx_valid
);
    localparam logic [3:0] HALF_LAST = 4'(HALF - 1);

    generate
        if (CW < 2 || CW > 32 || HALF < `SPS_SPI_HALF_MIN || HALF > 16) begin : g_chk
            $error("counter width or serial half period out of range");
        end
    endgenerate

    // --------------------------------------------------------------
    // pin synchronisers
    // --------------------------------------------------------------
    logic [1:0] sync1_reg;
    logic [1:0] sync2_reg;
    logic       s_miso;

    // interrupt pin is only ever sampled, never driven
    always_ff @(posedge clock) begin
        if (!nrst) begin
            sync1_reg <= 2'b00;
            sync2_reg <= 2'b00;
            irq_level <= 1'b0;
        end else begin
            sync1_reg <= {link.irq_line, link.miso_line};
            sync2_reg <= sync1_reg;
            irq_level <= sync2_reg[1];
        end
    end
    assign s_miso = sync2_reg[0];

    // --------------------------------------------------------------
    // power sequence
    // --------------------------------------------------------------
    sps_pkg::sps_hstate_t st_reg;
    sps_pkg::sps_spi_t    sp_reg;
    logic [CW-1:0]        cnt_reg;
    logic                 cnt_zero;
    logic                 enable_next;

    // enable stays up until the sequencer leaves ready: a withdrawn down request
    // must never bring the sensor back without a fresh settle
    assign cnt_zero    = (cnt_reg == '0);
    assign enable_next = (st_reg inside {sps_pkg::hs_clk_supply, sps_pkg::hs_t1,
                          sps_pkg::hs_t2, sps_pkg::hs_ready});

    // one interval counter serves t1, t2 and t3 in turn
    always_ff @(posedge clock) begin
        if (!nrst) begin
            st_reg  <= sps_pkg::hs_off;
            cnt_reg <= '0;
            t1_done <= 1'b0;
            t2_done <= 1'b0;
            t3_done <= 1'b0;
        end else begin
            t1_done <= 1'b0;
            t2_done <= 1'b0;
            t3_done <= 1'b0;
            if (!cnt_zero) begin
                cnt_reg <= cnt_reg - CW'(1);
            end
            unique case (st_reg)
                sps_pkg::hs_off: begin
                    if (power_up_req) begin
                        st_reg <= sps_pkg::hs_clk_supply;
                    end
                end
                sps_pkg::hs_clk_supply: begin
                    st_reg  <= sps_pkg::hs_t1;
                    cnt_reg <= t1_cycles;
                end
                sps_pkg::hs_t1: begin
                    if (cnt_zero) begin
                        t1_done <= 1'b1;
                        if (use_crystal) begin
                            st_reg  <= sps_pkg::hs_t2;
                            cnt_reg <= t2_cycles;
                        end else begin
                            st_reg <= sps_pkg::hs_ready;
                        end
                    end
                end
                sps_pkg::hs_t2: begin
                    if (cnt_zero) begin
                        t2_done <= 1'b1;
                        st_reg  <= sps_pkg::hs_ready;
                    end
                end
                sps_pkg::hs_ready: begin
                    // a byte in flight finishes before power goes
                    if (power_down_req && sp_reg == sps_pkg::sp_idle && !tx_valid) begin
                        st_reg <= sps_pkg::hs_pd_enable;
                    end
                end
                sps_pkg::hs_pd_enable: begin
                    st_reg  <= sps_pkg::hs_t3;
                    cnt_reg <= t3_cycles;
                end
                sps_pkg::hs_t3: begin
                    if (cnt_zero) begin
                        t3_done <= 1'b1;
                        st_reg  <= sps_pkg::hs_off;
                    end
                end
            endcase
        end
    end

    // supplies, enable, state control and phase status
    always_ff @(posedge clock) begin
        if (!nrst) begin
            link.clock_domain_supply <= 1'b0;
            link.primary_supplies    <= 1'b0;
            link.enable              <= 1'b0;
            link.ctrl                <= 1'b0;
            powered_up               <= 1'b0;
            powered_off              <= 1'b1;
        end else begin
            link.clock_domain_supply <= (st_reg != sps_pkg::hs_off) &&
                                        !(st_reg == sps_pkg::hs_t3 && cnt_zero);
            // primary stays on one cycle past enable, so enable always falls first
            link.primary_supplies    <= enable_next || (st_reg == sps_pkg::hs_pd_enable);
            link.enable              <= enable_next;
            // low through t1 and from power-down onward
            link.ctrl                <= (st_reg == sps_pkg::hs_ready) && ctrl_req &&
                                        !power_down_req;
            powered_up               <= (st_reg == sps_pkg::hs_ready);
            powered_off              <= (st_reg == sps_pkg::hs_off);
        end
    end

    // --------------------------------------------------------------
    // reference clock divider
    // --------------------------------------------------------------
    logic [3:0] div_reg;

    // stopped low with enable, so the clock pin never leads the supplies
    always_ff @(posedge clock) begin
        if (!nrst) begin
            div_reg                    <= 4'h0;
            link.reference_clock_input <= 1'b0;
        end else if (!enable_next || use_crystal) begin
            div_reg                    <= 4'h0;
            link.reference_clock_input <= 1'b0;
        end else if (div_reg == 4'(`SPS_REFCLK_DIV - 1)) begin
            div_reg                    <= 4'h0;
            link.reference_clock_input <= ~link.reference_clock_input;
        end else begin
            div_reg <= div_reg + 4'h1;
        end
    end

    // --------------------------------------------------------------
    // serial byte master, mode zero
    // --------------------------------------------------------------
    logic [3:0] hc_reg;
    logic [2:0] bit_reg;
    logic [7:0] tx_sh_reg;
    logic [7:0] rx_sh_reg;
    logic       half_end;
    logic       take;

    assign half_end = (hc_reg == HALF_LAST);
    assign take     = tx_valid & tx_ready;

    // half-period timer; reset by every phase change
    always_ff @(posedge clock) begin
        if (!nrst || sp_reg == sps_pkg::sp_idle || half_end) begin
            hc_reg <= 4'h0;
        end else begin
            hc_reg <= hc_reg + 4'h1;
        end
    end

    // select low from setup to hold, released for the gap
    always_ff @(posedge clock) begin
        if (!nrst) begin
            sp_reg    <= sps_pkg::sp_idle;
            bit_reg   <= 3'h0;
            tx_sh_reg <= 8'h00;
            rx_sh_reg <= 8'h00;
            rx_byte   <= 8'h00;
            rx_valid  <= 1'b0;
            tx_ready  <= 1'b0;
            link.sclk <= 1'b0;
            link.ss_n <= 1'b0;
            link.mosi <= 1'b0;
        end else begin
            rx_valid <= 1'b0;
            tx_ready <= (st_reg == sps_pkg::hs_ready) && (sp_reg == sps_pkg::sp_idle) &&
                        !take && !power_down_req;
            unique case (sp_reg)
                sps_pkg::sp_idle: begin
                    link.sclk <= 1'b0;
                    link.mosi <= 1'b0;
                    // inputs low outside ready, select idles high only while ready
                    link.ss_n <= (st_reg == sps_pkg::hs_ready);
                    if (take) begin
                        sp_reg    <= sps_pkg::sp_setup;
                        link.ss_n <= 1'b0;
                        link.mosi <= tx_byte[7];
                        tx_sh_reg <= tx_byte;
                        bit_reg   <= 3'h0;
                    end
                end
                sps_pkg::sp_setup, sps_pkg::sp_low: begin
                    if (half_end) begin
                        sp_reg    <= sps_pkg::sp_high;
                        link.sclk <= 1'b1;
                    end
                end
                sps_pkg::sp_high: begin
                    if (half_end) begin
                        // sample just before the falling edge moves miso
                        rx_sh_reg <= {rx_sh_reg[6:0], s_miso};
                        link.sclk <= 1'b0;
                        if (bit_reg == 3'h7) begin
                            sp_reg <= sps_pkg::sp_hold;
                        end else begin
                            sp_reg    <= sps_pkg::sp_low;
                            bit_reg   <= bit_reg + 3'h1;
                            tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
                            link.mosi <= tx_sh_reg[6];
                        end
                    end
                end
                sps_pkg::sp_hold: begin
                    if (half_end) begin
                        sp_reg    <= sps_pkg::sp_gap;
                        link.ss_n <= 1'b1;
                        link.mosi <= 1'b0;
                        rx_byte   <= rx_sh_reg;
                        rx_valid  <= 1'b1;
                    end
                end
                sps_pkg::sp_gap: begin
                    if (half_end) begin
                        sp_reg <= sps_pkg::sp_idle;
                    end
                end
                default: begin
                    sp_reg <= sps_pkg::sp_idle;
                end
            endcase
        end
    end
endmodule

// ==== hw/sps_link_if.sv ====
/*
 * wires between host and sensor: supplies, enable, state control,
 * reference clock, four-wire serial bus and interrupt.
 * assumes the bench resolves nothing else; pulled-down lines read low
 * while undriven.
 */
`timescale 1ns/1ps

interface sps_link_if;
    logic clock_domain_supply;
    logic primary_supplies;
    logic enable;
    logic ctrl;
    logic reference_clock_input;
    logic sclk;
    logic ss_n;
    logic mosi;
    logic miso_o;
    logic miso_oe_n;
    logic irq_o;
    logic irq_oe_n;
    logic miso_line;
    logic irq_line;

    // pull-downs hold undriven lines low
    assign miso_line = miso_oe_n ? 1'b0 : miso_o;
    assign irq_line  = irq_oe_n ? 1'b0 : irq_o;

    modport host (
        output clock_domain_supply, primary_supplies, enable, ctrl,
        output reference_clock_input, sclk, ss_n, mosi,
        input  miso_line, irq_line
    );

    modport dev (
        input  clock_domain_supply, primary_supplies, enable, ctrl,
        input  reference_clock_input, sclk, ss_n, mosi,
        output miso_o, miso_oe_n, irq_o, irq_oe_n
    );
endinterface

// ==== hw/sps_params.svh ====
/*
 * constants for the sensor power-enable sequencer: clock rate, settle time,
 * serial timing and command codes.
 * assumes it is included by bare name from both ends and the testbench.
 */
`ifndef SPS_PARAMS_SVH
`define SPS_PARAMS_SVH

// --------------------------------------------------------------
// clock and timing
// --------------------------------------------------------------
`define SPS_CLK_HZ          20000000
`define SPS_OSC_SETTLE_US   2000
`define SPS_OSC_SETTLE_CYC  (`SPS_OSC_SETTLE_US * (`SPS_CLK_HZ / 1000000))
`define SPS_SPI_HALF_CYC    8
`define SPS_SPI_HALF_MIN    6
`define SPS_REFCLK_DIV      1
`define SPS_CNT_W           24

// --------------------------------------------------------------
// serial commands and status layout
// --------------------------------------------------------------
`define SPS_CMD_START       8'h5a
`define SPS_ST_POWER_BIT    0
`define SPS_ST_READY_BIT    1
`define SPS_ST_STARTED_BIT  2
`define SPS_ST_IDLE_BIT     3

`endif

// ==== hw/sps_pkg.sv ====
/*
 * types used by the host end of the sensor power-enable sequencer.
 * assumes sps_params.svh holds the numeric constants.
 */
package sps_pkg;

    // host power sequence states
    typedef enum logic [2:0] {
        hs_off,
        hs_clk_supply,
        hs_t1,
        hs_t2,
        hs_ready,
        hs_pd_enable,
        hs_t3
    } sps_hstate_t;

    // host serial byte states
    typedef enum logic [2:0] {
        sp_idle,
        sp_setup,
        sp_high,
        sp_low,
        sp_hold,
        sp_gap
    } sps_spi_t;

endpackage

// ==== hw/sps_sensor_end.sv ====
/*
 * sensor end: power detection, oscillator settle, serial slave, program
 * start and interrupt pin control.
 * assumes the host keeps the power sequence; all link inputs are pins and
 * pass two flip-flops before use.
 */
`timescale 1ns/1ps
`include "sps_params.svh"

module sps_sensor_end #(
    parameter bit CRYSTAL    = 1'b1,
    parameter int SETTLE_CYC = `SPS_OSC_SETTLE_CYC
) (
    // clock and reset
    input  wire logic clock,
    input  wire logic nrst,
    // link
    sps_link_if.dev   link,
    // user side
    input  wire logic       irq_req,
    output logic            sensor_on,
    output logic            osc_running,
    output logic            spi_ready,
    output logic [7:0]      prog_byte,
    output logic            prog_byte_valid,
    output logic            program_started,
    output logic            idle_state
);
    localparam int SW = $clog2(SETTLE_CYC + 1);

    generate
        if (SETTLE_CYC < 1) begin : g_chk
            $error("settle count must be at least one cycle");
        end
    endgenerate

    // --------------------------------------------------------------
    // pin synchronisers
    // --------------------------------------------------------------
    logic [6:0] sync1_reg;
    logic [6:0] sync2_reg;
    logic       s_vio3, s_prim, s_en, s_ctrl, s_sclk, s_ss_n, s_mosi;

    // first stage feeds only the second
    always_ff @(posedge clock) begin
        if (!nrst) begin
            sync1_reg <= 7'h00;
            sync2_reg <= 7'h00;
        end else begin
            sync1_reg <= {link.clock_domain_supply, link.primary_supplies, link.enable,
                          link.ctrl, link.sclk, link.ss_n, link.mosi};
            sync2_reg <= sync1_reg;
        end
    end
    assign {s_vio3, s_prim, s_en, s_ctrl, s_sclk, s_ss_n, s_mosi} = sync2_reg;

    // --------------------------------------------------------------
    // power and oscillator
    // --------------------------------------------------------------
    logic          power_on;
    logic [SW-1:0] settle_cnt_reg;

    assign power_on = s_vio3 & s_prim & s_en;

    // oscillator runs only while enable is high; an external clock needs no settle
    always_ff @(posedge clock) begin
        if (!nrst) begin
            sensor_on      <= 1'b0;
            osc_running    <= 1'b0;
            spi_ready      <= 1'b0;
            settle_cnt_reg <= '0;
        end else begin
            sensor_on   <= power_on;
            osc_running <= CRYSTAL & s_en;
            if (!power_on) begin
                spi_ready      <= 1'b0;
                settle_cnt_reg <= '0;
            end else if (!CRYSTAL) begin
                spi_ready <= 1'b1;
            end else if (settle_cnt_reg == SW'(SETTLE_CYC - 1)) begin
                spi_ready <= 1'b1;
            end else if (!spi_ready) begin
                settle_cnt_reg <= settle_cnt_reg + SW'(1);
            end
        end
    end

    // --------------------------------------------------------------
    // serial slave, mode zero
    // --------------------------------------------------------------
    logic       sclk_prev_reg;
    logic       ss_prev_reg;
    logic [7:0] rx_sh_reg;
    logic [7:0] tx_sh_reg;
    logic [3:0] bit_cnt_reg;
    logic       sel;
    logic [7:0] status;

    assign sel    = ~s_ss_n & spi_ready;
    assign status = {4'h0, idle_state, program_started, spi_ready, sensor_on};

    // sample on rising, shift out on falling; select falling preloads status
    always_ff @(posedge clock) begin
        if (!nrst) begin
            sclk_prev_reg   <= 1'b0;
            ss_prev_reg     <= 1'b1;
            rx_sh_reg       <= 8'h00;
            tx_sh_reg       <= 8'h00;
            bit_cnt_reg     <= 4'h0;
            prog_byte       <= 8'h00;
            prog_byte_valid <= 1'b0;
        end else begin
            sclk_prev_reg   <= s_sclk;
            ss_prev_reg     <= s_ss_n;
            prog_byte_valid <= 1'b0;
            if (sel && ss_prev_reg) begin
                tx_sh_reg   <= status;
                bit_cnt_reg <= 4'h0;
            end else if (sel && s_sclk && !sclk_prev_reg) begin
                rx_sh_reg <= {rx_sh_reg[6:0], s_mosi};
                if (bit_cnt_reg == 4'h7) begin
                    prog_byte       <= {rx_sh_reg[6:0], s_mosi};
                    prog_byte_valid <= 1'b1;
                    bit_cnt_reg     <= 4'h0;
                end else begin
                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                end
            end else if (sel && !s_sclk && sclk_prev_reg) begin
                tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
            end
        end
    end

    // miso driven only while selected, so other slaves can share it
    always_ff @(posedge clock) begin
        if (!nrst) begin
            link.miso_o    <= 1'b0;
            link.miso_oe_n <= 1'b1;
        end else begin
            link.miso_o    <= tx_sh_reg[7];
            link.miso_oe_n <= ~sel;
        end
    end

    // --------------------------------------------------------------
    // program start, state control and interrupt
    // --------------------------------------------------------------
    // start byte begins the program; losing power ends it
    always_ff @(posedge clock) begin
        if (!nrst) begin
            program_started <= 1'b0;
            idle_state      <= 1'b0;
        end else begin
            if (!power_on) begin
                program_started <= 1'b0;
            end else if (prog_byte_valid && prog_byte == `SPS_CMD_START) begin
                program_started <= 1'b1;
            end
            idle_state <= program_started & s_ctrl & power_on;
        end
    end

    // high impedance until started, push-pull afterwards
    always_ff @(posedge clock) begin
        if (!nrst) begin
            link.irq_o    <= 1'b0;
            link.irq_oe_n <= 1'b1;
        end else begin
            link.irq_oe_n <= ~program_started;
            link.irq_o    <= program_started & irq_req;
        end
    end
endmodule

// ==== testbench/sps_link_checker.sv ====
/* assertions on the wires between host end and sensor end.
   assumes instantiation beside the link, on the host clock and reset. */
`timescale 1ns/1ps
module sps_link_checker (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // host driven lines
    input wire logic clock_domain_supply,
    input wire logic primary_supplies,
    input wire logic enable,
    input wire logic ctrl,
    input wire logic reference_clock_input,
    input wire logic sclk,
    input wire logic ss_n,
    input wire logic mosi,
    // sensor driven enable
    input wire logic irq_oe_n
);
    // --------------------------------------------------------------
    // power and serial checks
    // --------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    // power-down happens in three steps, enable first
    sequence s_enable_drop; $fell(enable); endsequence
    sequence s_primary_off; !primary_supplies && !enable; endsequence
    a_down_steps: assert property (s_enable_drop |=> s_primary_off)
        else $error("primary supplies not off after enable");
    a_vio3_first: assert property ((enable || primary_supplies) |-> clock_domain_supply)
        else $error("supply on before clock supply");
    a_ctrl_hold_low: assert property ($rose(enable) |-> !ctrl [*4])
        else $error("state control high in stable interval");
    a_refclk_idle: assert property (!enable |-> !reference_clock_input)
        else $error("reference clock runs while disabled");
    a_irq_release: assert property ($fell(enable) |-> ##[0:8] irq_oe_n)
        else $error("interrupt still driven after enable low");
    a_supply_gap: assert property ($fell(clock_domain_supply) |-> $past(!primary_supplies))
        else $error("clock supply off before primary");
    a_inputs_low: assert property ($fell(clock_domain_supply)
        |-> !(enable | ctrl | reference_clock_input | sclk | mosi | ss_n))
        else $error("input high when clock supply falls");
    a_frame_ends: assert property ($rose(ss_n) |-> !sclk && $past(!sclk))
        else $error("select released with clock high");
    a_sclk_framed: assert property (sclk |-> !ss_n)
        else $error("serial clock outside select");
endmodule

// ==== testbench/sps_testbench.sv ====
/* bench driving both ends joined by sps_link_if through their user sides.
   assumes the design files and the link checker are compiled first. */
`timescale 1ns/1ps
`include "sps_params.svh"
module testbench;
    // --------------------------------------------------------------
    // stimulus and observed signals
    // --------------------------------------------------------------
    logic clock = 1'b0, nrst = 1'b0, power_up_req = 1'b0, power_down_req = 1'b0;
    logic ctrl_req = 1'b1, irq_req = 1'b0, tx_valid = 1'b0, use_crystal = 1'b1, refclk_seen;
    logic [7:0] tx_byte = 8'h00, rx_byte, prog_byte, last_prog = 8'h00;
    logic [`SPS_CNT_W-1:0] t1_cycles = 'h4, t2_cycles = 'h3c, t3_cycles = 'h3;
    logic powered_up, powered_off, t1_done, t2_done, t3_done, irq_level, tx_ready, rx_valid;
    logic sensor_on, osc_running, spi_ready, prog_byte_valid, program_started, idle_state;
    int bad_count = 0, check_count = 0;
    wire [4:0] fl = {rx_valid, powered_up, t3_done, t2_done, t1_done};
    sps_link_if link();
    // crystal path first, then the external clock; short settle keeps the run brief
    sps_host_end u_sps_host_end (.clock, .nrst, .link(link), .power_up_req, .power_down_req,
        .use_crystal, .t1_cycles, .t2_cycles, .t3_cycles, .ctrl_req, .powered_up,
        .powered_off, .t1_done, .t2_done, .t3_done, .irq_level, .tx_byte, .tx_valid,
        .tx_ready, .rx_byte, .rx_valid);
    sps_sensor_end #(.CRYSTAL(1'b1), .SETTLE_CYC(20)) u_sps_sensor_end (.clock, .nrst,
        .link(link), .irq_req, .sensor_on, .osc_running, .spi_ready, .prog_byte,
        .prog_byte_valid, .program_started, .idle_state);
    sps_link_checker u_sps_link_checker (.clock, .nrst,
        .clock_domain_supply(link.clock_domain_supply), .enable(link.enable),
        .primary_supplies(link.primary_supplies), .ctrl(link.ctrl), .sclk(link.sclk),
        .reference_clock_input(link.reference_clock_input), .ss_n(link.ss_n),
        .mosi(link.mosi), .irq_oe_n(link.irq_oe_n));
    always #25 clock = ~clock;
    // program bytes are single-cycle pulses, so keep the last one
    always @(posedge clock) begin
        if (prog_byte_valid === 1'b1) last_prog <= prog_byte;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // bounded wait on one status flag
    task automatic wt(input int k);
        int n;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (fl[k] !== 1'b1 && n < 3000);
        if (n >= 3000) chk(8'h00, 8'h01);
    endtask
    task automatic xfer(input logic [7:0] b, input logic [7:0] exp);
        do @(posedge clock); while (tx_ready !== 1'b1);
        tx_byte <= b;
        tx_valid <= 1'b1;
        @(posedge clock);
        tx_valid <= 1'b0;
        wt(4);
        chk(rx_byte, exp);
    endtask
    task automatic close_out();
        $display("checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // --------------------------------------------------------------
    // test sequence; state control requested early to prove it waits
    // --------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        chk({powered_off, link.clock_domain_supply, program_started}, 8'h04);
        power_up_req <= 1'b1;
        wt(0);
        chk({link.clock_domain_supply, link.enable, link.primary_supplies, link.ctrl}, 8'h0e);
        wt(1);
        chk(osc_running, 8'h01);
        wt(3);
        power_up_req <= 1'b0;
        chk({sensor_on, spi_ready, link.irq_oe_n}, 8'h07);
        xfer(8'h11, 8'h03);
        chk(last_prog, 8'h11);
        xfer(8'h5a, 8'h03);
        irq_req <= 1'b1;
        repeat (8) @(posedge clock);
        chk({program_started, link.irq_oe_n, irq_level, idle_state}, 8'h0b);
        xfer(8'h00, 8'h0f);
        power_down_req <= 1'b1;
        wt(2);
        power_down_req <= 1'b0;
        chk({link.clock_domain_supply, link.primary_supplies, link.enable, link.ctrl,
             link.reference_clock_input, link.sclk, link.ss_n, link.mosi}, 8'h00);
        repeat (4) @(posedge clock);
        chk({osc_running, program_started, irq_level, powered_off}, 8'h01);
        // second cycle on the external clock: no settle wait, clock runs
        use_crystal <= 1'b0;
        power_up_req <= 1'b1;
        wt(0);
        @(posedge clock);
        chk({powered_up, link.irq_oe_n}, 8'h03);
        refclk_seen = link.reference_clock_input;
        @(posedge clock);
        chk(refclk_seen ^ link.reference_clock_input, 8'h01);
        power_up_req <= 1'b0;
        power_down_req <= 1'b1;
        wt(2);
        chk({link.enable, link.reference_clock_input, link.clock_domain_supply}, 8'h00);
        close_out();
    end
    // hang guard, far beyond the expected run
    initial begin
        repeat (20000) @(posedge clock);
        bad_count++;
        close_out();
    end
endmodule
